// ### adcddr_top.v
// Functional notes
// - a conversion starts on each rising edge of the sample clock unless the output buffer is full and not popped on that edge.
// - each sample reaches the outputs nine sample clock rising edges later while rx_ready stays high.
// - results are 12-bit words on parallel or DDR differential outputs.
// - output words use offset binary or two's complement coding.
// - each DDR pair carries bit 2k and bit 2k+1 time-multiplexed.
// - DDR mode drives a true/complement output clock beside the data.
// - one bit selects internal or external reference operation.
// - coarse gain bit applies one fixed 3.5 dB step.
// - fine gain field selects zero to six dB in 1 dB steps.
// - reset sets total gain to zero; from the next clock it follows the gain inputs.
// - even bits go out with clock rising, odd bits with falling.
// - format bit 0 gives two's complement, 1 gives straight binary.
`timescale 1ns/1ps
`include "adcddr_consts.vh"

module adcddr_top #(
   parameter WIDTH = `ADCDDR_WORD_BITS,
   parameter PAIRS = `ADCDDR_PAIR_COUNT,
   parameter LATENCY = `ADCDDR_LATENCY
) (
   input wire clock,
   input wire rst_n,
   input wire sample_clock,
   input wire [WIDTH-1:0] quantizer_code,
   input wire interface_ddr,
   input wire format_straight,
   input wire ref_external,
   input wire coarse_gain_on,
   input wire [`ADCDDR_FINE_BITS-1:0] fine_gain_db,
   input wire rx_ready,
   input wire common_mode_pin_in,
   output wire common_mode_pin_out,
   output reg common_mode_pin_oe_n,
   output reg ref_internal_active,
   output reg coarse_gain_applied,
   output reg [`ADCDDR_FINE_BITS-1:0] fine_gain_applied,
   output reg [WIDTH-1:0] cmos_data,
   output reg cmos_clock,
   output reg out_clock_true,
   output reg out_clock_complement,
   output wire pair0_true,
   output wire pair0_complement,
   output wire pair1_true,
   output wire pair1_complement,
   output wire pair2_true,
   output wire pair2_complement,
   output wire pair3_true,
   output wire pair3_complement,
   output wire pair4_true,
   output wire pair4_complement,
   output wire pair5_true,
   output wire pair5_complement,
   output reg word_valid
);
   reg sclk_meta;
   reg sclk_sync;
   reg sclk_prev;
   reg [WIDTH-1:0] code_meta;
   reg [WIDTH-1:0] code_sync;
   reg cmn_meta;
   reg cmn_sync;
   reg [WIDTH-1:0] pipe [0:LATENCY-2];
   reg [`ADCDDR_LAT_CNT_BITS-1:0] fill;
   reg [PAIRS-1:0] pair_t;
   reg [PAIRS-1:0] pair_c;
   reg [WIDTH-1:0] cur_word;
   reg [2:0] phase;
   wire rise;
   wire fall;
   wire pipe_full;
   wire advance;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [WIDTH-1:0] fifo_out_data;
   wire pop;
   wire [WIDTH-1:0] coded;
   wire [PAIRS-1:0] even_bits;
   wire [PAIRS-1:0] odd_bits;
   integer i;
   genvar k;

   // common-mode level shows only while the pin is driven
   assign common_mode_pin_out = ref_internal_active;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sclk_meta <= 1'b0;
         sclk_sync <= 1'b0;
         sclk_prev <= 1'b0;
         code_meta <= {WIDTH{1'b0}};
         code_sync <= {WIDTH{1'b0}};
         cmn_meta <= 1'b0;
         cmn_sync <= 1'b0;
      end else begin
         sclk_meta <= sample_clock;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         code_meta <= quantizer_code;
         code_sync <= code_meta;
         cmn_meta <= common_mode_pin_in;
         cmn_sync <= cmn_meta;
      end
   end

   assign rise = sclk_sync && !sclk_prev;
   assign fall = !sclk_sync && sclk_prev;

   // latency fill count
   // full once the last stage holds a real sample, so the first one is not lost
   assign pipe_full = (fill == (LATENCY[`ADCDDR_LAT_CNT_BITS-1:0] -
      {{(`ADCDDR_LAT_CNT_BITS-1){1'b0}}, 1'b1}));
   assign advance = rise && (fifo_in_ready || !pipe_full);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < LATENCY - 1; i = i + 1)
            pipe[i] <= {WIDTH{1'b0}};
         fill <= {`ADCDDR_LAT_CNT_BITS{1'b0}};
      end else if (advance) begin
         pipe[0] <= code_sync;
         for (i = 1; i < LATENCY - 1; i = i + 1)
            pipe[i] <= pipe[i-1];
         if (!pipe_full)
            fill <= fill + {{(`ADCDDR_LAT_CNT_BITS-1){1'b0}}, 1'b1};
      end
   end

   assign coded = (format_straight == `ADCDDR_FMT_STRAIGHT) ? pipe[LATENCY-2] :
      {~pipe[LATENCY-2][WIDTH-1], pipe[LATENCY-2][WIDTH-2:0]};

   adcddr_fifo2 #(
      .WIDTH(WIDTH)
   ) u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(advance && pipe_full),
      .in_ready(fifo_in_ready),
      .in_data(coded),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data)
   );

   assign pop = rise && rx_ready && fifo_out_valid && (phase != `ADCDDR_ST_HIGH);

   generate
      for (k = 0; k < PAIRS; k = k + 1) begin : g_split
         assign even_bits[k] = fifo_out_data[2*k];
         assign odd_bits[k] = cur_word[2*k+1];
      end
   endgenerate

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase <= `ADCDDR_ST_IDLE;
         cur_word <= {WIDTH{1'b0}};
         cmos_data <= {WIDTH{1'b0}};
         cmos_clock <= 1'b0;
         out_clock_true <= 1'b0;
         out_clock_complement <= 1'b1;
         pair_t <= {PAIRS{1'b0}};
         pair_c <= {PAIRS{1'b1}};
         word_valid <= 1'b0;
      end else begin
         case (phase)
            `ADCDDR_ST_IDLE, `ADCDDR_ST_LOW: begin
               if (pop) begin
                  cur_word <= fifo_out_data;
                  word_valid <= 1'b1;
                  phase <= `ADCDDR_ST_HIGH;
                  if (interface_ddr == `ADCDDR_IF_DDR) begin
                     pair_t <= even_bits;
                     pair_c <= ~even_bits;
                     out_clock_true <= 1'b1;
                     out_clock_complement <= 1'b0;
                  end else begin
                     cmos_data <= fifo_out_data;
                     cmos_clock <= 1'b1;
                  end
               end else if (rise) begin
                  word_valid <= 1'b0;
                  phase <= `ADCDDR_ST_IDLE;
               end
            end
            `ADCDDR_ST_HIGH: begin
               if (fall) begin
                  phase <= `ADCDDR_ST_LOW;
                  cmos_clock <= 1'b0;
                  if (interface_ddr == `ADCDDR_IF_DDR) begin
                     pair_t <= odd_bits;
                     pair_c <= ~odd_bits;
                     out_clock_true <= 1'b0;
                     out_clock_complement <= 1'b1;
                  end
               end
            end
            default: begin
               phase <= `ADCDDR_ST_IDLE;
            end
         endcase
      end
   end

   assign pair0_true = pair_t[0];
   assign pair0_complement = pair_c[0];
   assign pair1_true = pair_t[1];
   assign pair1_complement = pair_c[1];
   assign pair2_true = pair_t[2];
   assign pair2_complement = pair_c[2];
   assign pair3_true = pair_t[3];
   assign pair3_complement = pair_c[3];
   assign pair4_true = pair_t[4];
   assign pair4_complement = pair_c[4];
   assign pair5_true = pair_t[5];
   assign pair5_complement = pair_c[5];

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         coarse_gain_applied <= `ADCDDR_COARSE_OFF;
         fine_gain_applied <= `ADCDDR_FINE_MIN;
         ref_internal_active <= 1'b1;
         common_mode_pin_oe_n <= 1'b0;
      end else begin
         coarse_gain_applied <= coarse_gain_on;
         if (fine_gain_db > `ADCDDR_FINE_MAX)
            fine_gain_applied <= `ADCDDR_FINE_MAX;
         else
            fine_gain_applied <= fine_gain_db;
         ref_internal_active <= (ref_external == `ADCDDR_REF_INTERNAL);
         common_mode_pin_oe_n <= (ref_external == `ADCDDR_REF_EXTERNAL);
      end
   end

   // external reference level is sensed but only buffered in analog
   wire unused_cmn;
   assign unused_cmn = cmn_sync;
endmodule

// ### adcddr_consts.vh
`ifndef ADCDDR_CONSTS_VH
`define ADCDDR_CONSTS_VH

// word and pipeline shape
`define ADCDDR_WORD_BITS 12
`define ADCDDR_PAIR_COUNT 6
`define ADCDDR_LATENCY 9
`define ADCDDR_LAT_CNT_BITS 4

// gain settings
`define ADCDDR_FINE_BITS 3
`define ADCDDR_FINE_MIN 3'h0
`define ADCDDR_FINE_MAX 3'h6
`define ADCDDR_COARSE_OFF 1'h0

// data format: 0 two's complement, 1 straight binary
`define ADCDDR_FMT_TWOS 1'h0
`define ADCDDR_FMT_STRAIGHT 1'h1

// interface type
`define ADCDDR_IF_CMOS 1'h0
`define ADCDDR_IF_DDR 1'h1

// reference mode
`define ADCDDR_REF_INTERNAL 1'h0
`define ADCDDR_REF_EXTERNAL 1'h1

// output phase states, one-hot
`define ADCDDR_ST_IDLE 3'h1
`define ADCDDR_ST_HIGH 3'h2
`define ADCDDR_ST_LOW 3'h4

`endif

// ### adcddr_fifo2.v
`timescale 1ns/1ps
`include "adcddr_consts.vh"

module adcddr_fifo2 #(
   parameter WIDTH = `ADCDDR_WORD_BITS
) (
   input wire clock,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] slot [0:1];
   reg rd_ptr;
   reg wr_ptr;
   reg [1:0] count;
   wire push;
   wire pop;

   // a pop in the same cycle frees a slot, so a full buffer still accepts
   assign in_ready = (count != 2'h2) || pop;
   assign out_valid = (count != 2'h0);
   assign out_data = slot[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slot[0] <= {WIDTH{1'b0}};
         slot[1] <= {WIDTH{1'b0}};
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            slot[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push && !pop)
            count <= count + 2'h1;
         else if (pop && !push)
            count <= count - 2'h1;
      end
   end
endmodule

// ### adcddr_checker.sv
`timescale 1ns/1ps
`include "adcddr_consts.vh"
module adcddr_checker (
   input wire clock,
   input wire rst_n,
   input wire sample_clock,
   input wire interface_ddr,
   input wire ref_external,
   input wire coarse_gain_on,
   input wire [`ADCDDR_FINE_BITS-1:0] fine_gain_db,
   input wire ref_internal_active,
   input wire coarse_gain_applied,
   input wire [`ADCDDR_FINE_BITS-1:0] fine_gain_applied,
   input wire cmos_clock,
   input wire out_clock_true,
   input wire out_clock_complement,
   input wire pair0_true,
   input wire pair0_complement,
   input wire pair1_true,
   input wire pair1_complement,
   input wire pair2_true,
   input wire pair2_complement,
   input wire pair3_true,
   input wire pair3_complement,
   input wire pair4_true,
   input wire pair4_complement,
   input wire pair5_true,
   input wire pair5_complement,
   input wire word_valid
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_clock_pair_opposite: assert property (out_clock_complement != out_clock_true)
      else $error("clock pair");
   a_data_pair_opposite: assert property (pair0_complement != pair0_true &&
      pair1_complement != pair1_true && pair2_complement != pair2_true &&
      pair3_complement != pair3_true && pair4_complement != pair4_true &&
      pair5_complement != pair5_true) else $error("data pair");
   a_ref_follows: assert property ($past(rst_n) |->
      ref_internal_active == !$past(ref_external)) else $error("ref flag");
   a_coarse_follows: assert property ($past(rst_n) |->
      coarse_gain_applied == $past(coarse_gain_on)) else $error("coarse gain");
   a_fine_clamped: assert property ($past(rst_n) |-> fine_gain_applied ==
      (($past(fine_gain_db) == 3'h7) ? 3'h6 : $past(fine_gain_db))) else $error("fine gain");
   a_word_on_rise: assert property ($rose(out_clock_true) |->
      sample_clock && word_valid && interface_ddr) else $error("ddr word start");
   a_odd_on_fall: assert property ($fell(out_clock_true) |-> !sample_clock)
      else $error("ddr fall");
   a_even_held: assert property (out_clock_true && $past(out_clock_true) |->
      $stable(pair0_true)) else $error("even bits moved");
   a_cmos_word: assert property ($rose(cmos_clock) |->
      sample_clock && word_valid && !interface_ddr) else $error("cmos word");
endmodule

bind adcddr_top adcddr_checker chk (
   .clock, .rst_n, .sample_clock, .interface_ddr, .ref_external, .coarse_gain_on,
   .fine_gain_db, .ref_internal_active, .coarse_gain_applied, .fine_gain_applied,
   .cmos_clock, .out_clock_true, .out_clock_complement, .pair0_true, .pair0_complement,
   .pair1_true, .pair1_complement, .pair2_true, .pair2_complement, .pair3_true,
   .pair3_complement, .pair4_true, .pair4_complement, .pair5_true, .pair5_complement,
   .word_valid
);

// ### adcddr_rx_model.sv
`timescale 1ns/1ps
module adcddr_rx_model (
   input wire clock,
   input wire rst_n,
   input wire stall,
   input wire ddr,
   input wire out_clock_true,
   input wire cmos_clock,
   input wire [11:0] cmos_data,
   input wire [5:0] pair_true,
   output reg rx_ready = 1'b1,
   output reg [11:0] rx_word = 12'h000,
   output reg rx_strobe = 1'b0
);
   reg prev_ddr = 1'b0;
   reg prev_cmos = 1'b0;
   reg [5:0] even = 6'h00;
   integer k;
   always @(posedge clock) begin
      prev_ddr <= out_clock_true;
      prev_cmos <= cmos_clock;
      rx_strobe <= 1'b0;
      if (rst_n && ddr && out_clock_true && !prev_ddr) begin
         even <= pair_true;
      end
      if (rst_n && ddr && !out_clock_true && prev_ddr) begin
         for (k = 0; k < 6; k = k + 1) begin
            rx_word[2 * k] <= even[k];
            rx_word[2 * k + 1] <= pair_true[k];
         end
         rx_strobe <= 1'b1;
      end
      if (rst_n && !ddr && cmos_clock && !prev_cmos) begin
         rx_word <= cmos_data;
         rx_strobe <= 1'b1;
      end
   end
   always @(negedge clock) begin
      rx_ready <= !stall;
   end
endmodule

// ### adcddr_top_tb.sv
`timescale 1ns/1ps
module adcddr_top_tb;
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   reg sample_clock = 1'b0;
   reg interface_ddr = 1'b1;
   reg format_straight = 1'b0;
   reg ref_external = 1'b0;
   reg coarse_gain_on = 1'b0;
   reg stall = 1'b0;
   reg [11:0] quantizer_code = 12'h000;
   reg [2:0] fine_gain_db = 3'h0;
   wire rx_ready, common_mode_pin_oe_n, ref_internal_active, coarse_gain_applied, cmos_clock;
   wire out_clock_true, out_clock_complement, word_valid, rx_strobe;
   wire [2:0] fine_gain_applied;
   wire [11:0] cmos_data, rx_word;
   wire pair0_true, pair0_complement, pair1_true, pair1_complement, pair2_true;
   wire pair2_complement, pair3_true, pair3_complement, pair4_true, pair4_complement;
   wire pair5_true, pair5_complement;
   wire common_mode_pin_out;
   wire [5:0] cfg = {ref_internal_active, common_mode_pin_oe_n, coarse_gain_applied,
      fine_gain_applied};
   integer n_mismatch = 0;
   integer checks_done = 0;
   integer n_rx = 0;
   logic [11:0] exp_q[$];

   adcddr_top DUT (
      .clock, .rst_n, .sample_clock, .quantizer_code, .interface_ddr, .format_straight,
      .ref_external, .coarse_gain_on, .fine_gain_db, .rx_ready, .common_mode_pin_in(1'b1),
      .common_mode_pin_out, .common_mode_pin_oe_n, .ref_internal_active, .coarse_gain_applied,
      .fine_gain_applied, .cmos_data, .cmos_clock, .out_clock_true, .out_clock_complement,
      .pair0_true, .pair0_complement, .pair1_true, .pair1_complement, .pair2_true,
      .pair2_complement, .pair3_true, .pair3_complement, .pair4_true, .pair4_complement,
      .pair5_true, .pair5_complement, .word_valid
   );
   adcddr_rx_model rx (
      .clock, .rst_n, .stall, .ddr(interface_ddr), .out_clock_true, .cmos_clock, .cmos_data,
      .pair_true({pair5_true, pair4_true, pair3_true, pair2_true, pair1_true, pair0_true}),
      .rx_ready, .rx_word, .rx_strobe
   );

   always #2.5 clock = ~clock;

   task check(input logic [11:0] got, input logic [11:0] want);
      checks_done = checks_done + 1;
      if (got !== want) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // code held steady across the sync delay of the rise
   task one_rise(input logic [11:0] code);
      quantizer_code = code;
      repeat (6) @(negedge clock);
      sample_clock = 1'b1;
      exp_q.push_back(format_straight ? code : code ^ 12'h800);
      repeat (12) @(negedge clock);
      sample_clock = 1'b0;
      repeat (7) @(negedge clock);
   endtask

   task run_phase(input logic ddr, input logic fmt);
      integer i;
      rst_n = 1'b0;
      interface_ddr = ddr;
      format_straight = fmt;
      repeat (4) @(negedge clock);
      check({6'h00, cfg}, 12'h020);
      rst_n = 1'b1;
      exp_q.delete();
      n_rx = 0;
      repeat (10) @(negedge clock);
      for (i = 0; i < 17; i = i + 1) begin
         stall = (i == 12);
         one_rise(12'(12'h801 + i * 12'h2A7));
         if (i == 8) check(12'(n_rx), 12'h000);
         if (i == 9) check(12'(n_rx), 12'h001);
         if (i == 10) check({11'h0, n_rx != 0}, 12'h001);
      end
      check(12'(n_rx), 12'h007);
   endtask

   always @(posedge clock) begin
      if (rx_strobe === 1'b1) begin
         n_rx = n_rx + 1;
         check(rx_word, exp_q.size() ? exp_q.pop_front() : 12'hXXX);
      end
   end

   initial begin : main
      integer i;
      run_phase(1'b1, 1'b0);
      for (i = 0; i < 8; i = i + 1) begin
         fine_gain_db = i[2:0];
         coarse_gain_on = i[0];
         ref_external = i[1];
         repeat (2) @(negedge clock);
         check({6'h00, ~i[1], i[1], i[0], (i == 7) ? 3'h6 : i[2:0]}, {6'h00, cfg});
         check({11'h000, common_mode_pin_out}, {11'h000, ~i[1]});
      end
      fine_gain_db = 3'h0;
      coarse_gain_on = 1'b0;
      ref_external = 1'b0;
      repeat (2) @(negedge clock);
      run_phase(1'b1, 1'b1);
      run_phase(1'b0, 1'b1);
      run_phase(1'b0, 1'b0);
      end_sim;
   end

   initial begin
      #50000;
      n_mismatch = n_mismatch + 1;
      end_sim;
   end
endmodule
